// *** logic/uafc_pkg.sv ***
`default_nettype none

package uafc_pkg;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_TRIGGER = 8'h08;
    localparam logic [7:0] OFS_MODEM_CTRL = 8'h10;
    localparam logic [7:0] OFS_MODEM_STAT = 8'h18;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
    localparam logic [7:0] OFS_CTS_IEN = 8'h28;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int MCR_SW_RTS = 1;
    localparam int MCR_AUTO_RTS = 6;
    localparam int MCR_AUTO_CTS = 7;
    localparam int MSR_CTS_LEVEL = 4;
    localparam int EV_DELTA_CTS = 0;
    localparam int EV_RTS_OFF = 1;
    localparam int EV_RTS_ON = 2;
    localparam int EV_COUNT = 3;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] MCR_RESET = 8'h00;
    localparam logic [1:0] TRIGGER_RESET = 2'h0;
    localparam logic [2:0] MASK_RESET = 3'h0;

    // ****************************************
    // Receive trigger levels in characters
    // ****************************************
    localparam int FILL_WIDTH = 5;
    localparam logic [4:0] TRIG_LEVEL0 = 5'h01;
    localparam logic [4:0] TRIG_LEVEL1 = 5'h04;
    localparam logic [4:0] TRIG_LEVEL2 = 5'h08;
    localparam logic [4:0] TRIG_LEVEL3 = 5'h0E;
    localparam logic [4:0] TRIG_FLOOR = 5'h00;

    // Transmit gate states
    typedef enum logic [1:0] {
        UAFC_TX_IDLE = 2'b00,
        UAFC_TX_GO = 2'b01,
        UAFC_TX_BUSY = 2'b10
    } uafc_tx_type;

endpackage

`default_nettype wire

// *** logic/uafc_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

module uafc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Asynchronous level in, synchronised level out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    // Two stages; first stage feeds nothing but the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '1;
            sync_out <= '1;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

`default_nettype wire

// *** logic/uafc_top.sv ***
// How it works
// - Bit 6 of the modem line control register turns automatic RTS on at 1 and off at 0, and resets to 0.
// - Bit 7 of the modem line control register turns automatic CTS on at 1 and off at 0, and resets to 0.
// - With automatic RTS on, RTS goes high as soon as the receive fill level reaches the trigger level.
// - With automatic RTS on, RTS goes low again once the fill level falls to the next lower trigger level.
// - After RTS goes high the receiver still takes the character the remote sender had already begun.
// - With automatic CTS on, a new character may start only while the CTS input is low.
// - With automatic RTS off, the RTS pin follows the software level bit.
// - With automatic RTS on, the actual RTS level is copied into the software level bit.
// - With automatic RTS on, software writes to the software level bit are ignored.
// - With trigger setting 2, RTS goes high at 8 characters and low again at 4.
// - Bit 1 of the modem line control register is the software level for the RTS pin.
// - In automatic CTS mode a CTS change still sets delta CTS but interrupts only with CTS interrupt enable set.
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none

module uafc_top #(
    parameter int FILL_W = uafc_pkg::FILL_WIDTH
) (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Receive side
    input wire logic [FILL_W-1:0] rx_fill_level,
    input wire logic rx_char_done,
    output logic rx_accept,
    // Transmit side
    input wire logic tx_pending,
    input wire logic tx_boundary,
    output logic tx_start,
    // Modem pins
    input wire logic cts_n,
    output logic rts_n,
    // Interrupt
    output logic irq
);

    // ****************************************
    // Control state
    // ****************************************
    logic [7:0] mcr_r;
    logic [1:0] trig_r;
    logic [2:0] status_r;
    logic [2:0] mask_r;
    logic cts_ien_r;
    logic cts_sync;
    logic cts_prev_r;
    logic rts_off_r;
    logic rts_off_nxt;
    logic [FILL_W-1:0] trig_hi;
    logic [FILL_W-1:0] trig_lo;
    logic [2:0] ev;
    logic wr_en;
    logic auto_rts;
    logic auto_cts;
    logic cts_ok;
    logic irq_nxt;
    uafc_pkg::uafc_tx_type tx_state_r;

    assign auto_rts = mcr_r[uafc_pkg::MCR_AUTO_RTS];
    assign auto_cts = mcr_r[uafc_pkg::MCR_AUTO_CTS];
    assign wr_en = psel & penable & pready & pwrite;

    // CTS pin crosses into pclk before use
    uafc_sync #(.WIDTH(1)) u_cts_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(cts_n),
        .sync_out(cts_sync)
    );

    // ****************************************
    // APB slave
    // ****************************************

    // One access cycle; answer is prepared in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel & ~penable) begin
                if (paddr == uafc_pkg::OFS_MODEM_CTRL) begin
                    prdata <= {24'h00_0000, mcr_r};
                end else if (paddr == uafc_pkg::OFS_TRIGGER) begin
                    prdata <= {30'h0000_0000, trig_r};
                end else if (paddr == uafc_pkg::OFS_MODEM_STAT) begin
                    prdata <= {27'h000_0000, ~cts_sync, 3'h0, status_r[uafc_pkg::EV_DELTA_CTS]};
                end else if (paddr == uafc_pkg::OFS_IRQ_STAT) begin
                    prdata <= {29'h0000_0000, status_r};
                end else if (paddr == uafc_pkg::OFS_IRQ_MASK) begin
                    prdata <= {29'h0000_0000, mask_r};
                end else if (paddr == uafc_pkg::OFS_CTS_IEN) begin
                    prdata <= {31'h0000_0000, cts_ien_r};
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // Modem line control: enables and the software RTS level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mcr_r <= uafc_pkg::MCR_RESET;
        end else begin
            if (wr_en && paddr == uafc_pkg::OFS_MODEM_CTRL) begin
                mcr_r[uafc_pkg::MCR_AUTO_RTS] <= pwdata[uafc_pkg::MCR_AUTO_RTS];
                mcr_r[uafc_pkg::MCR_AUTO_CTS] <= pwdata[uafc_pkg::MCR_AUTO_CTS];
            end
            if (auto_rts) begin
                // Hardware owns the bit; a write is dropped here
                mcr_r[uafc_pkg::MCR_SW_RTS] <= ~rts_off_nxt;
            end else if (wr_en && paddr == uafc_pkg::OFS_MODEM_CTRL) begin
                mcr_r[uafc_pkg::MCR_SW_RTS] <= pwdata[uafc_pkg::MCR_SW_RTS];
            end
        end
    end

    // Trigger, mask and CTS interrupt enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_r <= uafc_pkg::TRIGGER_RESET;
            mask_r <= uafc_pkg::MASK_RESET;
            cts_ien_r <= 1'b0;
        end else if (wr_en) begin
            if (paddr == uafc_pkg::OFS_TRIGGER) begin
                trig_r <= pwdata[1:0];
            end else if (paddr == uafc_pkg::OFS_IRQ_MASK) begin
                mask_r <= pwdata[2:0];
            end else if (paddr == uafc_pkg::OFS_CTS_IEN) begin
                cts_ien_r <= pwdata[0];
            end
        end
    end

    // ****************************************
    // Automatic RTS
    // ****************************************

    // Upper trigger and the one a step below it
    always_comb begin
        case (trig_r)
            2'h0: begin
                trig_hi = FILL_W'(uafc_pkg::TRIG_LEVEL0);
                trig_lo = FILL_W'(uafc_pkg::TRIG_FLOOR);
            end
            2'h1: begin
                trig_hi = FILL_W'(uafc_pkg::TRIG_LEVEL1);
                trig_lo = FILL_W'(uafc_pkg::TRIG_LEVEL0);
            end
            2'h2: begin
                trig_hi = FILL_W'(uafc_pkg::TRIG_LEVEL2);
                trig_lo = FILL_W'(uafc_pkg::TRIG_LEVEL1);
            end
            default: begin
                trig_hi = FILL_W'(uafc_pkg::TRIG_LEVEL3);
                trig_lo = FILL_W'(uafc_pkg::TRIG_LEVEL2);
            end
        endcase
    end

    // Hysteresis keeps RTS from chattering around one level
    always_comb begin
        rts_off_nxt = rts_off_r;
        if (!auto_rts) begin
            rts_off_nxt = ~mcr_r[uafc_pkg::MCR_SW_RTS];
        end else if (rx_fill_level >= trig_hi) begin
            rts_off_nxt = 1'b1;
        end else if (rx_fill_level <= trig_lo) begin
            rts_off_nxt = 1'b0;
        end
    end

    // RTS pin straight from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rts_off_r <= 1'b1;
            rts_n <= 1'b1;
        end else begin
            rts_off_r <= rts_off_nxt;
            rts_n <= rts_off_nxt;
        end
    end

    // Receiver is never refused for flow reasons, only for a truly full store
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_accept <= 1'b1;
        end else begin
            rx_accept <= ~(&rx_fill_level);
        end
    end

    // ****************************************
    // Automatic CTS transmit gate
    // ****************************************
    assign cts_ok = ~auto_cts | ~cts_sync;

    // Start decided only at a boundary; a running character is left alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state_r <= uafc_pkg::UAFC_TX_IDLE;
            tx_start <= 1'b0;
        end else begin
            tx_start <= 1'b0;
            case (tx_state_r)
                uafc_pkg::UAFC_TX_IDLE: begin
                    if (tx_pending && tx_boundary && cts_ok) begin
                        tx_state_r <= uafc_pkg::UAFC_TX_GO;
                        tx_start <= 1'b1;
                    end
                end
                uafc_pkg::UAFC_TX_GO: begin
                    tx_state_r <= uafc_pkg::UAFC_TX_BUSY;
                end
                uafc_pkg::UAFC_TX_BUSY: begin
                    if (tx_boundary) begin
                        tx_state_r <= uafc_pkg::UAFC_TX_IDLE;
                    end
                end
                default: begin
                    tx_state_r <= uafc_pkg::UAFC_TX_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Events and interrupt
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cts_prev_r <= 1'b1;
        end else begin
            cts_prev_r <= cts_sync;
        end
    end

    assign ev[uafc_pkg::EV_DELTA_CTS] = cts_sync ^ cts_prev_r;
    assign ev[uafc_pkg::EV_RTS_OFF] = rts_off_nxt & ~rts_off_r;
    assign ev[uafc_pkg::EV_RTS_ON] = ~rts_off_nxt & rts_off_r;

    // Sticky bits, write one to clear; a new event wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= 3'h0;
        end else if (wr_en && paddr == uafc_pkg::OFS_IRQ_STAT) begin
            status_r <= (status_r & ~pwdata[2:0]) | ev;
        end else begin
            status_r <= status_r | ev;
        end
    end

    // Delta CTS interrupts in auto mode only with its own enable
    always_comb begin
        irq_nxt = |(status_r & mask_r & 3'h6);
        if (status_r[0] && mask_r[0] && (!auto_cts || cts_ien_r)) begin
            irq_nxt = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_nxt;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence s_fill_high;
        auto_rts && rx_fill_level >= trig_hi;
    endsequence

    sequence s_fill_low;
        auto_rts && rx_fill_level <= trig_lo;
    endsequence

    a_rts_goes_high: assert property (@(posedge pclk) disable iff (!presetn)
        s_fill_high |=> rts_n) else $error("RTS not dropped at trigger");

    a_rts_goes_low: assert property (@(posedge pclk) disable iff (!presetn)
        s_fill_low |=> !rts_n) else $error("RTS not restored at lower trigger");

    a_rts_sw_follow: assert property (@(posedge pclk) disable iff (!presetn)
        !auto_rts && $stable(mcr_r) |=> rts_n == !$past(mcr_r[1])) else $error("RTS ignores software level");

    a_rts_mirror_bit: assert property (@(posedge pclk) disable iff (!presetn)
        auto_rts && $past(auto_rts) |-> mcr_r[1] == !rts_n) else $error("RTS level not mirrored");

    a_sw_bit_locked: assert property (@(posedge pclk) disable iff (!presetn)
        auto_rts && wr_en && paddr == uafc_pkg::OFS_MODEM_CTRL && pwdata[1] && rts_off_nxt |=> !mcr_r[1])
        else $error("Software wrote RTS bit in auto mode");

    a_enables_written: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == uafc_pkg::OFS_MODEM_CTRL |=> auto_rts == $past(pwdata[6]) && auto_cts == $past(pwdata[7]))
        else $error("Flow enables not stored");

    a_cts_holds_tx: assert property (@(posedge pclk) disable iff (!presetn)
        tx_start |-> $past(!auto_cts || !cts_sync)) else $error("Started with CTS high");

    a_start_at_edge: assert property (@(posedge pclk) disable iff (!presetn)
        tx_start |-> $past(tx_boundary) ##1 !tx_start) else $error("Start away from boundary");

    a_delta_cts_set: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(cts_sync) |=> status_r[0]) else $error("Delta CTS lost");

    a_cts_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
        auto_cts && !cts_ien_r && status_r == 3'h1 |=> !irq) else $error("CTS interrupt not gated");

    a_rx_still_open: assert property (@(posedge pclk) disable iff (!presetn)
        rts_n && rx_fill_level < 5'h1F |=> rx_accept) else $error("Receiver closed by flow control");

endmodule

`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    localparam logic [7:0] MCR = uafc_pkg::OFS_MODEM_CTRL;
    localparam logic [7:0] STA = uafc_pkg::OFS_IRQ_STAT;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, rx_accept, tx_start, rts_n, irq, cts_n, err;
    logic hold = 1'b0, tx_pending = 1'b0, tx_boundary = 1'b0;
    logic [4:0] fill = 5'h00;
    logic [2:0] lag = 3'h0;
    int n_mismatch = 0, checks_done = 0, seed = 5304, exp_rts = 1, trig, auto = 0, c, v;
    int hi[4] = '{1, 4, 8, 14};
    int lo[4] = '{0, 1, 4, 8};

    always #12.5 pclk = ~pclk;

    uafc_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .rx_fill_level(fill), .rx_char_done(1'b0), .rx_accept, .tx_pending, .tx_boundary,
        .tx_start, .cts_n, .rts_n, .irq);
    uafc_remote u_far (.pclk, .presetn, .hold, .lag, .cts_n);

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One APB transfer; request held until pready is seen, only the watchdog ends a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        chk("pready_setup", 0, {31'h0, pready});
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Model follows the hysteresis of the request line
    task automatic set_fill(input int f);
        @(posedge pclk);
        fill <= f[4:0];
        if (auto != 0 && f >= hi[trig]) begin
            exp_rts = 1;
        end else if (auto != 0 && f <= lo[trig]) begin
            exp_rts = 0;
        end
        repeat (2) @(posedge pclk);
        #1;
        chk("rts_n", exp_rts, {31'h0, rts_n});
    endtask

    // Counts start pulses, sampled after each edge has settled
    task automatic cnt_start(input int cyc);
        c = 0;
        repeat (cyc) begin
            @(posedge pclk);
            #1;
            if (tx_start === 1'b1) begin
                c++;
            end
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog far beyond the expected few hundred cycles
    initial begin
        #(25 * 20000);
        n_mismatch++;
        finish_test();
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, MCR, 0);
        chk("mcr", 0, rd);
        chk("rts_n", 1, {31'h0, rts_n});
        apb(0, 8'hFC, 0);
        chk("slverr", 1, {31'h0, err});
        apb(1, MCR, 32'h2);
        apb(0, MCR, 0);
        chk("mcr", 2, rd);
        chk("rts_n", 0, {31'h0, rts_n});
        apb(1, MCR, 0);
        apb(0, MCR, 0);
        chk("rts_n", 1, {31'h0, rts_n});
        $display("test reset and manual done");
        apb(1, uafc_pkg::OFS_IRQ_MASK, 32'h6);
        for (trig = 0; trig < 4; trig++) begin
            apb(1, uafc_pkg::OFS_TRIGGER, trig);
            apb(1, MCR, 32'h42);
            auto = 1;
            set_fill(0);
            set_fill(hi[trig]);
            set_fill(hi[trig] + 1);
            chk("rx_accept", 1, {31'h0, rx_accept});
            apb(0, MCR, 0);
            chk("mcr", 32'h40, rd);
            apb(1, MCR, 32'h42);
            apb(0, MCR, 0);
            chk("mcr", 32'h40, rd);
            chk("irq", 1, {31'h0, irq});
            apb(0, STA, 0);
            chk("sta", 32'h2, rd & 32'h2);
            apb(1, STA, 32'h7);
            apb(0, STA, 0);
            chk("irq", 0, {31'h0, irq});
            if (hi[trig] - lo[trig] > 1) begin
                v = lo[trig] + 1 + ($unsigned($random(seed)) % (hi[trig] - lo[trig] - 1));
                set_fill(v);
            end
            set_fill(lo[trig]);
            apb(0, STA, 0);
            chk("sta", 32'h4, rd & 32'h4);
            apb(1, STA, 32'h7);
            // The write that ends auto mode still meets a locked bit, so the mirrored level stays
            apb(1, MCR, 0);
            auto = 0;
            exp_rts = 0;
            set_fill(0);
            apb(1, MCR, 0);
            exp_rts = 1;
            set_fill(0);
        end
        set_fill(31);
        chk("rx_accept", 0, {31'h0, rx_accept});
        set_fill(0);
        $display("test auto request done");
        apb(1, uafc_pkg::OFS_IRQ_MASK, 32'h1);
        apb(1, MCR, 32'h80);
        @(posedge pclk);
        hold <= 1'b1;
        lag <= 3'h3;
        repeat (8) @(posedge pclk);
        apb(1, STA, 32'h7);
        @(posedge pclk);
        tx_pending <= 1'b1;
        tx_boundary <= 1'b1;
        cnt_start(10);
        chk("tx_start", 0, c);
        @(posedge pclk);
        hold <= 1'b0;
        cnt_start(12);
        chk("tx_started", 1, {31'h0, c > 0});
        chk("irq", 0, {31'h0, irq});
        apb(0, uafc_pkg::OFS_MODEM_STAT, 0);
        chk("msr", 32'h11, rd & 32'h11);
        apb(1, uafc_pkg::OFS_CTS_IEN, 1);
        apb(0, STA, 0);
        chk("irq", 1, {31'h0, irq});
        @(posedge pclk);
        tx_boundary <= 1'b0;
        repeat (4) @(posedge pclk);
        cnt_start(10);
        chk("tx_start", 0, c);
        apb(1, MCR, 0);
        @(posedge pclk);
        hold <= 1'b1;
        tx_boundary <= 1'b1;
        repeat (8) @(posedge pclk);
        cnt_start(10);
        chk("tx_started", 1, {31'h0, c > 0});
        $display("test auto clear done");
        finish_test();
    end
endmodule
`default_nettype wire

// *** testbench/uafc_remote.sv ***
`timescale 1ns/100ps
`default_nettype none

// Far-end sender: drives the clear-to-send line with a chosen lag
module uafc_remote (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Commands from the bench
    input wire logic hold,
    input wire logic [2:0] lag,
    // Handshake line
    output logic cts_n
);
    logic [7:0] pipe_r;

    // Delay line lets the far side answer promptly or slowly
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pipe_r <= 8'h00;
        end else begin
            pipe_r <= {pipe_r[6:0], hold};
        end
    end

    // Hold-off is raised lag cycles after hold, at once for lag 0, with no regard to where a character stands
    assign cts_n = (lag == 3'h0) ? hold : pipe_r[lag - 3'h1];
endmodule
`default_nettype wire
